// file: pin_share_pkg.sv
// Purpose: constants for the shared port pin mux of two can controllers
//          and the i2c module
// Assumes: one clock, asynchronous active-high reset
// Notes:   bit positions refer to the 8-bit port pin vector
package pin_share_pkg;
  localparam int PORT_W      = 8;
  localparam int PIN_SCL     = 4;
  localparam int PIN_RX_A    = 5;
  localparam int PIN_TX_A    = 6;
  localparam int PIN_SDA     = 7;
  localparam int PIN_RX_B    = 4;
  localparam int PIN_TX_B    = 7;
  localparam int SEG_W       = 4;
  localparam int SEG_LO      = 0;
  localparam int ADDR_SEL    = 8;
  localparam int IRQ_VEC_N   = 4;
  localparam int MSG_OBJ_ONE = 32;
  localparam int MSG_OBJ_ALL = 64;
  localparam logic RST_CAN_A_SEL = 1'b1;
  localparam logic RST_CAN_B_SEL = 1'b0;
  localparam logic RST_PARALLEL  = 1'b0;
endpackage

// file: sync2.sv
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: clock enable freezes state
// Notes:   first stage read only by second stage
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_q;
  logic [W-1:0] s2_d;

  always_comb begin
    s1_d = ce_i ? d_i : s1_q;
    s2_d = ce_i ? s1_q : s2_q;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign q_o = s2_q;
endmodule

// file: pin_share.sv
// Purpose: routes two can controllers, i2c and port b onto shared pins
// Assumes: controllers and i2c engine live outside; all their signals
//          are on clk_sys_i; pads are synchronised here
// Notes:   every output is registered, so pins lag one cycle
`timescale 1ns/100ps
module pin_share (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // configuration writes
  input  wire logic                      perif_cfg_we_i,
  input  wire logic                      can_a_select_bit_i,
  input  wire logic                      can_b_select_bit_i,
  input  wire logic                      misc_reg_enable_bit_i,
  input  wire logic                      i2c_enable_bit_i,
  input  wire logic                      peripheral_bus_enable_bit_i,
  input  wire logic                      misc_cfg_we_i,
  input  wire logic                      can_parallel_bit_i,
  // bus address for can chip selects
  input  wire logic                      bus_sel_i,
  input  wire logic [15:0]               bus_addr_i,
  // port b registers
  input  wire logic [7:0]                port_b_data_reg_i,
  input  wire logic [7:0]                port_b_direction_reg_i,
  input  wire logic [7:0]                port_b_open_drain_reg_i,
  input  wire logic [7:0]                seg_addr_i,
  input  wire logic [7:0]                seg_addr_en_i,
  // controller sides
  input  wire logic                      can_a_transmit_out_i,
  input  wire logic                      can_b_transmit_out_i,
  input  wire logic                      scl_out_i,
  input  wire logic                      sda_out_i,
  input  wire logic [3:0]                can_a_irq_i,
  input  wire logic [3:0]                can_b_irq_i,
  input  wire logic [3:0]                other_irq_i,
  input  wire logic                      i2c_err_irq_i,
  input  wire logic                      i2c_tx_irq_i,
  input  wire logic                      i2c_rx_irq_i,
  // pads
  input  wire logic [7:0]                pad_in_i,
  output logic      [7:0]                pad_out_o,
  output logic      [7:0]                pad_oe_o,
  // to controllers
  output logic                           can_a_receive_in_o,
  output logic                           can_b_receive_in_o,
  output logic                           scl_in_o,
  output logic                           sda_in_o,
  output logic                           can_a_cs_o,
  output logic                           can_b_cs_o,
  output logic [7:0]                     port_b_pin_o,
  // status
  output logic                           can_a_sel_o,
  output logic                           can_b_sel_o,
  output logic                           can_parallel_o,
  output logic                           misc_access_o,
  output logic                           seg_limited_o,
  output logic [6:0]                     msg_obj_count_o,
  output logic [3:0]                     on_chip_peripheral_bus_irq_o,
  output logic                           i2c_err_irq_o,
  output logic                           i2c_tx_irq_o,
  output logic                           i2c_rx_irq_o
);
  // configuration state
  logic can_a_sel_q, can_a_sel_d;
  logic can_b_sel_q, can_b_sel_d;
  logic misc_en_q, misc_en_d;
  logic i2c_en_q, i2c_en_d;
  logic par_q, par_d;
  logic misc_ok;

  // synchronised pads
  logic [7:0] pin_s;

  sync2 #(
    .W(pin_share_pkg::PORT_W)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .d_i      (pad_in_i),
    .q_o      (pin_s)
  );

  // control bits; software orders selects before the bus enable
  always_comb begin
    can_a_sel_d = can_a_sel_q;
    can_b_sel_d = can_b_sel_q;
    misc_en_d   = misc_en_q;
    i2c_en_d    = i2c_en_q;
    par_d       = par_q;
    misc_ok     = misc_en_q && peripheral_bus_enable_bit_i;
    if (perif_cfg_we_i) begin
      can_a_sel_d = can_a_select_bit_i;
      can_b_sel_d = can_b_select_bit_i;
      misc_en_d   = misc_reg_enable_bit_i;
      i2c_en_d    = i2c_enable_bit_i;
    end
    if (misc_cfg_we_i && misc_ok) begin
      par_d = can_parallel_bit_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      can_a_sel_q <= pin_share_pkg::RST_CAN_A_SEL;
      can_b_sel_q <= pin_share_pkg::RST_CAN_B_SEL;
      misc_en_q   <= 1'b0;
      i2c_en_q    <= 1'b0;
      par_q       <= pin_share_pkg::RST_PARALLEL;
    end else if (ce_i) begin
      can_a_sel_q <= can_a_sel_d;
      can_b_sel_q <= can_b_sel_d;
      misc_en_q   <= misc_en_d;
      i2c_en_q    <= i2c_en_d;
      par_q       <= par_d;
    end
  end

  // pin routing
  logic [7:0] out_d, oe_d;
  logic       rx_a_d, rx_b_d, scl_d, sda_d;
  logic       cs_a_d, cs_b_d;
  logic       can_used;
  logic [6:0] obj_d;
  logic [3:0] irq_d;
  logic       tx_a_eff;

  always_comb begin
    can_used = can_a_sel_q || can_b_sel_q;
    // ordinary port pins: open-drain drives only a low level
    for (int i = 0; i < pin_share_pkg::PORT_W; i++) begin
      out_d[i] = port_b_data_reg_i[i];
      oe_d[i]  = port_b_direction_reg_i[i] &&
                 (!port_b_open_drain_reg_i[i] || !port_b_data_reg_i[i]);
    end
    // segment lines, only four when can is used
    for (int i = 0; i < pin_share_pkg::PORT_W; i++) begin
      if (seg_addr_en_i[i] &&
          (!can_used || i < pin_share_pkg::SEG_W)) begin
        out_d[i] = seg_addr_i[i];
        oe_d[i]  = 1'b1;
      end
    end
    // transmit of a, wired-and with b in parallel mode
    tx_a_eff = can_a_sel_q ? can_a_transmit_out_i : 1'b1;
    if (par_q && can_b_sel_q) begin
      tx_a_eff = tx_a_eff && can_b_transmit_out_i;
    end
    if (can_a_sel_q || (par_q && can_b_sel_q)) begin
      out_d[pin_share_pkg::PIN_TX_A] = tx_a_eff;
      oe_d[pin_share_pkg::PIN_TX_A]  =
        !port_b_open_drain_reg_i[pin_share_pkg::PIN_TX_A] || !tx_a_eff;
    end
    if (can_b_sel_q && !par_q) begin
      out_d[pin_share_pkg::PIN_TX_B] = can_b_transmit_out_i;
      oe_d[pin_share_pkg::PIN_TX_B]  =
        !port_b_open_drain_reg_i[pin_share_pkg::PIN_TX_B] ||
        !can_b_transmit_out_i;
    end
    // i2c overrides port and can b on scl/sda
    if (i2c_en_q) begin
      out_d[pin_share_pkg::PIN_SCL] = 1'b0;
      oe_d[pin_share_pkg::PIN_SCL]  = !scl_out_i;
      out_d[pin_share_pkg::PIN_SDA] = 1'b0;
      oe_d[pin_share_pkg::PIN_SDA]  = !sda_out_i;
    end // else port, segment or can b function stays
    rx_a_d = pin_s[pin_share_pkg::PIN_RX_A];
    rx_b_d = par_q ? pin_s[pin_share_pkg::PIN_RX_A]
                   : pin_s[pin_share_pkg::PIN_RX_B];
    scl_d  = i2c_en_q ? pin_s[pin_share_pkg::PIN_SCL] : 1'b1;
    sda_d  = i2c_en_q ? pin_s[pin_share_pkg::PIN_SDA] : 1'b1;
    // chip selects split by a8, same offsets below
    cs_a_d = bus_sel_i && can_a_sel_q &&
             !bus_addr_i[pin_share_pkg::ADDR_SEL];
    cs_b_d = bus_sel_i && can_b_sel_q &&
             bus_addr_i[pin_share_pkg::ADDR_SEL];
    // message objects: frame format handled inside each controller
    obj_d = 7'h00;
    if (can_a_sel_q && can_b_sel_q) begin
      obj_d = 7'(pin_share_pkg::MSG_OBJ_ALL);
    end else if (can_used) begin
      obj_d = 7'(pin_share_pkg::MSG_OBJ_ONE);
    end
    // shared vectors
    irq_d = other_irq_i |
            (can_a_sel_q ? can_a_irq_i : 4'h0) |
            (can_b_sel_q ? can_b_irq_i : 4'h0);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pad_out_o          <= 8'h00;
      pad_oe_o           <= 8'h00;
      can_a_receive_in_o <= 1'b1;
      can_b_receive_in_o <= 1'b1;
      scl_in_o           <= 1'b1;
      sda_in_o           <= 1'b1;
      can_a_cs_o         <= 1'b0;
      can_b_cs_o         <= 1'b0;
      port_b_pin_o       <= 8'h00;
      can_a_sel_o        <= pin_share_pkg::RST_CAN_A_SEL;
      can_b_sel_o        <= pin_share_pkg::RST_CAN_B_SEL;
      can_parallel_o     <= pin_share_pkg::RST_PARALLEL;
      misc_access_o      <= 1'b0;
      seg_limited_o      <= 1'b0;
      msg_obj_count_o    <= 7'h00;
      on_chip_peripheral_bus_irq_o         <= 4'h0;
      i2c_err_irq_o      <= 1'b0;
      i2c_tx_irq_o       <= 1'b0;
      i2c_rx_irq_o       <= 1'b0;
    end else if (ce_i) begin
      pad_out_o          <= out_d;
      pad_oe_o           <= oe_d;
      can_a_receive_in_o <= rx_a_d;
      can_b_receive_in_o <= rx_b_d;
      scl_in_o           <= scl_d;
      sda_in_o           <= sda_d;
      can_a_cs_o         <= cs_a_d;
      can_b_cs_o         <= cs_b_d;
      port_b_pin_o       <= pin_s;
      can_a_sel_o        <= can_a_sel_q;
      can_b_sel_o        <= can_b_sel_q;
      can_parallel_o     <= par_q;
      misc_access_o      <= misc_ok;
      seg_limited_o      <= can_used;
      msg_obj_count_o    <= obj_d;
      on_chip_peripheral_bus_irq_o         <= irq_d;
      i2c_err_irq_o      <= i2c_en_q && i2c_err_irq_i;
      i2c_tx_irq_o       <= i2c_en_q && i2c_tx_irq_i;
      i2c_rx_irq_o       <= i2c_en_q && i2c_rx_irq_i;
    end
  end
endmodule

// file: pin_share_asserts.sv
// Purpose: port checker for pin_share
// Assumes: single clock domain, asynchronous active-high reset
// Notes:   mirrors of the config bits; ok marks five quiet cycles
`timescale 1ns/100ps
module pin_share_asserts (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        perif_cfg_we_i,
  input wire logic        can_a_select_bit_i,
  input wire logic        can_b_select_bit_i,
  input wire logic        misc_reg_enable_bit_i,
  input wire logic        i2c_enable_bit_i,
  input wire logic        peripheral_bus_enable_bit_i,
  input wire logic        misc_cfg_we_i,
  input wire logic        can_parallel_bit_i,
  input wire logic        bus_sel_i,
  input wire logic        scl_out_i,
  input wire logic        sda_out_i,
  input wire logic        i2c_err_irq_i,
  input wire logic        i2c_tx_irq_i,
  input wire logic        i2c_rx_irq_i,
  input wire logic        i2c_err_irq_o,
  input wire logic        i2c_tx_irq_o,
  input wire logic        i2c_rx_irq_o,
  input wire logic        can_a_receive_in_o,
  input wire logic        can_b_receive_in_o,
  input wire logic        can_a_cs_o,
  input wire logic        can_b_cs_o,
  input wire logic        can_a_sel_o,
  input wire logic        can_b_sel_o,
  input wire logic        can_parallel_o,
  input wire logic        seg_limited_o,
  input wire logic [15:0] bus_addr_i,
  input wire logic [3:0]  can_a_irq_i,
  input wire logic [3:0]  can_b_irq_i,
  input wire logic [3:0]  other_irq_i,
  input wire logic [3:0]  on_chip_peripheral_bus_irq_o,
  input wire logic [7:0]  pad_out_o,
  input wire logic [7:0]  pad_oe_o,
  input wire logic [6:0]  msg_obj_count_o
);
  logic [2:0] cnt_q;
  logic       ca_q, cb_q, me_q, ic_q, par_q, ok;
  assign ok = (cnt_q == 3'h5);
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 3'h0;
      {ca_q, cb_q, me_q, ic_q, par_q} <= 5'h10;
    end else begin
      if (!ce_i || perif_cfg_we_i || misc_cfg_we_i) begin
        cnt_q <= 3'h0;
      end else if (cnt_q != 3'h5) begin
        cnt_q <= cnt_q + 3'h1;
      end
      if (ce_i && perif_cfg_we_i) begin
        {ca_q, cb_q, me_q, ic_q} <= {can_a_select_bit_i,
          can_b_select_bit_i, misc_reg_enable_bit_i, i2c_enable_bit_i};
      end
      if (ce_i && misc_cfg_we_i && me_q && peripheral_bus_enable_bit_i) begin
        par_q <= can_parallel_bit_i;
      end
    end
  end
  default clocking dck @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_cs_req;
    ok && bus_sel_i && ca_q && cb_q && ce_i;
  endsequence
  a_reset_values: assert property (disable iff (1'h0)
    rst_i |-> can_a_sel_o && !can_b_sel_o && pad_oe_o == 8'h00)
    else $error("reset selection wrong");
  a_sel_status: assert property (ok |-> can_a_sel_o == ca_q &&
    can_b_sel_o == cb_q && can_parallel_o == par_q)
    else $error("config status wrong");
  a_seg_limit: assert property (ok |-> seg_limited_o == (ca_q | cb_q))
    else $error("segment limit wrong");
  a_msg_count: assert property (ok |-> msg_obj_count_o ==
    (ca_q && cb_q ? 7'h40 : (ca_q || cb_q) ? 7'h20 : 7'h00))
    else $error("object count wrong");
  a_chip_select: assert property (s_cs_req |=>
    can_a_cs_o == !$past(bus_addr_i[8]) && can_b_cs_o == $past(bus_addr_i[8]))
    else $error("chip select wrong");
  a_i2c_pins: assert property (ok && ic_q |->
    pad_out_o[4] == 1'h0 && pad_out_o[7] == 1'h0 &&
    pad_oe_o[4] == !$past(scl_out_i) && pad_oe_o[7] == !$past(sda_out_i))
    else $error("i2c pin drive wrong");
  a_irq_merge: assert property (ok && ca_q && cb_q &&
    $past(peripheral_bus_enable_bit_i) |->
    on_chip_peripheral_bus_irq_o == $past(can_a_irq_i | can_b_irq_i | other_irq_i))
    else $error("bus irq merge wrong");
  a_i2c_irq: assert property (ok && ic_q |-> {i2c_err_irq_o,
    i2c_tx_irq_o, i2c_rx_irq_o} == $past({i2c_err_irq_i, i2c_tx_irq_i,
    i2c_rx_irq_i})) else $error("i2c irq lines wrong");
  a_par_receive: assert property (ok && par_q |->
    can_a_receive_in_o == can_b_receive_in_o)
    else $error("parallel receive split");
endmodule
bind pin_share pin_share_asserts u_chk (.*);

// file: pad_partner.sv
// Purpose: can transceiver and i2c device on the port b pads
// Assumes: every pad has a pull-up
// Notes:   an undriven pad reads high
`timescale 1ns/100ps
module pad_partner (
  input  wire logic [7:0] pad_out_i,
  input  wire logic [7:0] pad_oe_i,
  input  wire logic       can_dom_i,
  input  wire logic       i2c_low_i,
  output logic      [7:0] pad_in_o
);
  logic [7:0] lvl;
  assign lvl = (pad_oe_i & pad_out_i) | ~pad_oe_i;
  always_comb begin
    pad_in_o = lvl;
    pad_in_o[5] = lvl[5] & lvl[6] & ~can_dom_i;
    pad_in_o[4] = lvl[4] & ~i2c_low_i;
    pad_in_o[7] = lvl[7] & ~i2c_low_i;
  end
endmodule

// file: tb.sv
// Purpose: self-checking bench for pin_share
// Assumes: pad_partner resolves the pads
// Notes:   waits six cycles after each change
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module tb;
  logic clk_sys_i = 0, rst_i = 0, ce_i = 1, perif_cfg_we_i = 0, bus_sel_i = 0;
  logic can_a_select_bit_i = 1, can_b_select_bit_i = 0, i2c_enable_bit_i = 0;
  logic misc_reg_enable_bit_i = 0, peripheral_bus_enable_bit_i = 0;
  logic misc_cfg_we_i = 0, can_parallel_bit_i = 0, scl_out_i = 1;
  logic sda_out_i = 1, can_a_transmit_out_i = 1, can_b_transmit_out_i = 1;
  logic can_dom = 0, i2c_low = 0, i2c_err_irq_i = 0, i2c_tx_irq_i = 0;
  logic i2c_rx_irq_i = 0;
  logic [15:0] bus_addr_i = 16'h0000;
  logic [7:0] port_b_data_reg_i = 8'h00, port_b_direction_reg_i = 8'h00;
  logic [7:0] port_b_open_drain_reg_i = 8'h00, seg_addr_i = 8'h00;
  logic [7:0] seg_addr_en_i = 8'h00, pad_in_i, pad_out_o, pad_oe_o;
  logic [7:0] port_b_pin_o;
  logic [3:0] can_a_irq_i = 4'h0, can_b_irq_i = 4'h0, other_irq_i = 4'h0;
  logic [3:0] on_chip_peripheral_bus_irq_o;
  logic [6:0] msg_obj_count_o;
  logic can_a_receive_in_o, can_b_receive_in_o, scl_in_o, sda_in_o;
  logic can_a_cs_o, can_b_cs_o, can_a_sel_o, can_b_sel_o, can_parallel_o;
  logic misc_access_o, seg_limited_o, i2c_err_irq_o, i2c_tx_irq_o;
  logic i2c_rx_irq_o;
  int err_total = 0;
  int tests_run = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  pin_share u_dut (.*);
  pad_partner u_partner (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .can_dom_i(can_dom), .i2c_low_i(i2c_low), .pad_in_o(pad_in_i));
  task automatic wt(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic cfg(logic a, logic b, logic m, logic i);
    @(posedge clk_sys_i);
    perif_cfg_we_i <= 1;
    {can_a_select_bit_i, can_b_select_bit_i} <= {a, b};
    {misc_reg_enable_bit_i, i2c_enable_bit_i} <= {m, i};
    @(posedge clk_sys_i);
    perif_cfg_we_i <= 0;
    wt(6);
  endtask
  task automatic misc(logic p);
    @(posedge clk_sys_i);
    misc_cfg_we_i <= 1;
    can_parallel_bit_i <= p;
    @(posedge clk_sys_i);
    misc_cfg_we_i <= 0;
    wt(6);
  endtask
  task automatic t_reset();
    `CHK(can_a_sel_o, 1'h1)
    `CHK(can_b_sel_o, 1'h0)
    `CHK(msg_obj_count_o, 7'h20)
    `CHK(seg_limited_o, 1'h1)
  endtask
  task automatic t_can();
    @(posedge clk_sys_i);
    can_a_transmit_out_i <= 0;
    wt(6);
    `CHK(pad_in_i[6], 1'h0)
    `CHK(can_a_receive_in_o, 1'h0)
    cfg(1, 1, 0, 0);
    peripheral_bus_enable_bit_i <= 1;
    {can_a_transmit_out_i, can_b_transmit_out_i, i2c_low} <= 3'h3;
    {can_a_irq_i, can_b_irq_i, other_irq_i, bus_sel_i} <= 13'h0291;
    bus_addr_i <= 16'h0100;
    wt(6);
    `CHK(pad_in_i[7], 1'h0)
    `CHK(can_b_receive_in_o, 1'h0)
    `CHK({pad_out_o[7], pad_oe_o[7]}, 2'h3)
    `CHK({can_a_cs_o, can_b_cs_o}, 2'h1)
    `CHK(on_chip_peripheral_bus_irq_o, 4'hD)
    `CHK(msg_obj_count_o, 7'h40)
    port_b_open_drain_reg_i <= 8'h80;
    {can_b_transmit_out_i, i2c_low, bus_addr_i[8]} <= 3'h4;
    wt(6);
    `CHK(pad_oe_o[7], 1'h0)
    `CHK({can_a_cs_o, can_b_cs_o}, 2'h2)
    port_b_open_drain_reg_i <= 8'h00;
    bus_sel_i <= 0;
  endtask
  task automatic t_par();
    misc(1);
    `CHK(can_parallel_o, 1'h0)
    cfg(1, 1, 1, 0);
    peripheral_bus_enable_bit_i <= 0;
    misc(1);
    `CHK({can_parallel_o, misc_access_o}, 2'h0)
    peripheral_bus_enable_bit_i <= 1;
    misc(1);
    `CHK(can_parallel_o, 1'h1)
    `CHK(misc_access_o, 1'h1)
    {port_b_direction_reg_i, port_b_data_reg_i} <= 16'h8080;
    {can_a_transmit_out_i, can_b_transmit_out_i} <= 2'h2;
    wt(6);
    `CHK(pad_in_i[6], 1'h0)
    `CHK({pad_out_o[7], pad_oe_o[7]}, 2'h3)
    {can_b_transmit_out_i, can_dom} <= 2'h3;
    wt(6);
    `CHK(pad_in_i[6], 1'h1)
    `CHK({can_a_receive_in_o, can_b_receive_in_o}, 2'h0)
    can_dom <= 0;
    misc(0);
  endtask
  task automatic t_i2c();
    cfg(1, 1, 1, 1);
    {port_b_direction_reg_i, port_b_data_reg_i} <= 16'hFFFF;
    {scl_out_i, i2c_low, i2c_err_irq_i, i2c_rx_irq_i} <= 4'h7;
    wt(6);
    `CHK({pad_oe_o[4], pad_out_o[4]}, 2'h2)
    `CHK(pad_oe_o[7], 1'h0)
    `CHK(sda_in_o, 1'h0)
    `CHK(scl_in_o, 1'h0)
    `CHK({i2c_err_irq_o, i2c_tx_irq_o, i2c_rx_irq_o}, 3'h5)
    {scl_out_i, i2c_low} <= 2'h2;
    cfg(1, 0, 1, 0);
    `CHK({pad_oe_o[4], pad_out_o[4]}, 2'h3)
    `CHK(port_b_pin_o, 8'hFF)
  endtask
  task automatic t_seg();
    {seg_addr_en_i, seg_addr_i} <= 16'hFF00;
    wt(6);
    `CHK(pad_out_o, 8'hF0)
    cfg(0, 0, 0, 0);
    `CHK({seg_limited_o, msg_obj_count_o}, 8'h00)
    `CHK(pad_out_o, 8'h00)
    ce_i <= 0;
    seg_addr_i <= 8'h0F;
    wt(6);
    `CHK(pad_out_o, 8'h00)
    ce_i <= 1;
    wt(6);
    `CHK(pad_out_o, 8'h0F)
    rst_i <= 1;
    @(posedge clk_sys_i);
    rst_i <= 0;
    wt(6);
    `CHK({can_a_sel_o, can_b_sel_o, can_parallel_o}, 3'h4)
    `CHK(msg_obj_count_o, 7'h20)
  endtask
  task automatic summarize();
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_i <= 1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 0;
    wt(6);
    t_reset();
    t_can();
    t_par();
    t_i2c();
    t_seg();
    summarize();
  end
  initial begin
    #40000;
    err_total++;
    summarize();
  end
endmodule
